// >>> adc_threshold_status_config.sv
// Purpose: threshold decoder, status, clock divider and input selects
// Assumes: test and update pulses come from the computation engine
// Notes: rcClk is the dedicated oscillator, sampled as a pin
`timescale 1ns/10ps
`include "adc_cfg.svh"
module adc_threshold_status_config (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [`ADDR_W-1:0] regAddr,
	input wire adc_pkg::byte_t regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output adc_pkg::byte_t regRdata,
	input wire adc_pkg::value_t computedError,
	input wire adc_pkg::value_t upperThreshold,
	input wire adc_pkg::value_t lowerThreshold,
	input wire logic thresholdTest,
	input wire logic overflowEvent,
	input wire logic computeUpdate,
	input wire logic triggerIn,
	input wire logic prechargeDone,
	input wire logic acquireDone,
	input wire logic conversionDone,
	input wire logic rcClk,
	output logic thresholdIrq,
	output logic convClkTick,
	output logic [2:0] refRoute,
	output logic [5:0] posChannel,
	output logic posConnected,
	output logic [6:0] posInternal,
	output logic [5:0] negChannel,
	output logic negConnected,
	output logic [6:0] negInternal,
	output logic [2:0] stageCode
);
	import adc_pkg::*;

	// true when a channel code reaches some input
	function automatic logic chanLive(input logic [5:0] c,
		input logic isNeg);
		logic gap;
		gap = (c >= `CH_GAP1_LO && c <= `CH_GAP1_HI) ||
			(c >= `CH_GAP2_LO && c <= `CH_GAP2_HI);
		chanLive = !gap && !(isNeg && c == `CH_GUARD);
	endfunction

	// one-hot of internal sources, bit 0 is the amplifier output
	function automatic logic [6:0] chanInternal(input logic [5:0] c);
		logic [6:0] oh;
		oh = 7'h00;
		if (c >= `CH_INT_FIRST) begin
			oh[3'(c - `CH_INT_FIRST)] = 1'b1;
		end
		chanInternal = oh;
	endfunction

	function automatic logic [2:0] stageOf(input stage_t s);
		case (s)
			stPre1: stageOf = `STAGE_PRE1;
			stAcq1: stageOf = `STAGE_ACQ1;
			stConv1: stageOf = `STAGE_CONV1;
			stSusp: stageOf = `STAGE_SUSP;
			stPre2: stageOf = `STAGE_PRE2;
			stAcq2: stageOf = `STAGE_ACQ2;
			stConv2: stageOf = `STAGE_CONV2;
			default: stageOf = `STAGE_IDLE;
		endcase
	endfunction

	logic [5:0] posChan_r;
	logic [5:0] negChan_r;
	logic [1:0] refSel_r;
	logic [5:0] clkDiv_r;
	logic [2:0] tmd_r;
	logic go_r;
	logic continuous_operation_r;
	logic double_sample_enable_r;
	logic soi_r;
	logic rcSrc_r;
	logic ovf_r;
	logic upper_r;
	logic lower_r;
	logic upd_r;
	stage_t stage_r;
	stage_t stage_nxt;
	logic [2:0] stageCode_r;
	byte_t rdata_r;
	logic irq_r;
	logic tick_r;
	logic [5:0] divCnt_r;
	logic divPhase_r;
	logic rcMeta_r;
	logic rcSync_r;
	logic rcPrev_r;
	logic [2:0] refRoute_r;
	logic posLive_r;
	logic negLive_r;
	logic [6:0] posInt_r;
	logic [6:0] negInt_r;

	// register decode
	wire hitPos = regAddr == `OFF_POS_CHAN;
	wire hitNeg = regAddr == `OFF_NEG_CHAN;
	wire hitStat = regAddr == `OFF_STATUS;
	wire hitRef = regAddr == `OFF_REF_SEL;
	wire hitDiv = regAddr == `OFF_CLK_DIV;
	wire hitCtl = regAddr == `OFF_CONTROL;
	wire hitMode = regAddr == `OFF_TH_MODE;
	wire wrStat = regWr && hitStat;
	wire wrCtl = regWr && hitCtl;

	// signed view of the compared values
	wire signed [15:0] errS = computedError;
	wire signed [15:0] upS = upperThreshold;
	wire signed [15:0] loS = lowerThreshold;
	wire aboveUp = errS > upS;
	wire belowLo = errS < loS;
	wire insideWin = (errS > loS) && (errS < upS);

	logic hitMatch;
	always_comb begin
		case (tmd_r)
			`TMD_ALWAYS: hitMatch = 1'b1;
			`TMD_ABOVE: hitMatch = aboveUp;
			`TMD_ATMOST_UP: hitMatch = !aboveUp;
			`TMD_OUTSIDE: hitMatch = belowLo || aboveUp;
			`TMD_INSIDE: hitMatch = insideWin;
			`TMD_ATLEAST_LOW: hitMatch = !belowLo;
			`TMD_BELOW: hitMatch = belowLo;
			default: hitMatch = 1'b0;
		endcase
	end
	wire irqEvent = thresholdTest && hitMatch;

	// conversion request stop; a write of go in the same cycle loses
	// to the hardware stop so a met condition is never missed
	wire soiStop = irqEvent && continuous_operation_r && soi_r;
	wire cycleEnd = stage_r == stConv2 ||
		(stage_r == stConv1 && !double_sample_enable_r);
	wire singleStop = conversionDone && cycleEnd && !continuous_operation_r;

	// stage sequencer
	always_comb begin
		stage_nxt = stage_r;
		case (stage_r)
			stIdle:
				if (go_r && (triggerIn || continuous_operation_r))
					stage_nxt = stPre1;
			stPre1:
				if (prechargeDone)
					stage_nxt = stAcq1;
			stAcq1:
				if (acquireDone)
					stage_nxt = stConv1;
			stConv1:
				if (conversionDone) begin
					if (!double_sample_enable_r)
						stage_nxt = (go_r && continuous_operation_r && !soiStop) ? stPre1 : stIdle;
					else if (continuous_operation_r)
						stage_nxt = stPre2;
					else
						stage_nxt = stSusp;
				end
			stSusp:
				if (!go_r)
					stage_nxt = stIdle;
				else if (triggerIn)
					stage_nxt = stPre2;
			stPre2:
				if (prechargeDone)
					stage_nxt = stAcq2;
			stAcq2:
				if (acquireDone)
					stage_nxt = stConv2;
			stConv2:
				if (conversionDone)
					stage_nxt = (go_r && continuous_operation_r && !soiStop) ? stPre1 : stIdle;
			default:
				stage_nxt = stIdle;
		endcase
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			stage_r <= stIdle;
			stageCode_r <= `STAGE_IDLE;
		end else begin
			stage_r <= stage_nxt;
			stageCode_r <= stageOf(stage_nxt);
		end
	end

	// configuration registers
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			posChan_r <= `RST_CHAN;
			negChan_r <= `RST_CHAN;
			refSel_r <= `RST_REF;
			clkDiv_r <= `RST_DIV;
			tmd_r <= `RST_MODE;
		end else if (regWr) begin
			if (hitPos)
				posChan_r <= regWdata[5:0];
			if (hitNeg)
				negChan_r <= regWdata[5:0];
			if (hitRef)
				refSel_r <= regWdata[1:0];
			if (hitDiv)
				clkDiv_r <= regWdata[5:0];
			if (hitMode)
				tmd_r <= regWdata[2:0];
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			continuous_operation_r <= 1'b0;
			double_sample_enable_r <= 1'b0;
			soi_r <= 1'b0;
			rcSrc_r <= 1'b0;
		end else if (wrCtl) begin
			continuous_operation_r <= regWdata[`CT_CONTINUOUS_OPERATION];
			double_sample_enable_r <= regWdata[`CT_DOUBLE_SAMPLE_ENABLE];
			soi_r <= regWdata[`CT_SOI];
			rcSrc_r <= regWdata[`CT_RCSRC];
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn)
			go_r <= 1'b0;
		else if (soiStop || singleStop)
			go_r <= 1'b0;
		else if (wrCtl)
			go_r <= regWdata[`CT_GO];
	end

	// status flags: hardware set wins over software clear
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			ovf_r <= 1'b0;
			upd_r <= 1'b0;
			upper_r <= 1'b0;
			lower_r <= 1'b0;
		end else begin
			if (overflowEvent)
				ovf_r <= 1'b1;
			else if (wrStat && !regWdata[`ST_OVF])
				ovf_r <= 1'b0;
			if (computeUpdate || overflowEvent)
				upd_r <= 1'b1;
			else if (wrStat && !regWdata[`ST_UPD] && stage_r != stSusp)
				upd_r <= 1'b0;
			if (thresholdTest) begin
				upper_r <= aboveUp;
				lower_r <= belowLo;
			end
		end
	end

	// rcClk is asynchronous, so two flops before the edge detect
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			rcMeta_r <= 1'b0;
			rcSync_r <= 1'b0;
			rcPrev_r <= 1'b0;
		end else begin
			rcMeta_r <= rcClk;
			rcSync_r <= rcMeta_r;
			rcPrev_r <= rcSync_r;
		end
	end
	wire rcRise = rcSync_r && !rcPrev_r;

	// two halves of n+1 cycles each give one tick per 2(n+1)
	wire divWrap = divCnt_r >= clkDiv_r;
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			divCnt_r <= 6'h00;
			divPhase_r <= 1'b0;
			tick_r <= 1'b0;
		end else if (rcSrc_r) begin
			divCnt_r <= 6'h00;
			divPhase_r <= 1'b0;
			tick_r <= rcRise;
		end else begin
			divCnt_r <= divWrap ? 6'h00 : divCnt_r + 6'h01;
			if (divWrap)
				divPhase_r <= !divPhase_r;
			tick_r <= divWrap && divPhase_r;
		end
	end

	// selection outputs, registered so they never glitch
	logic [2:0] refRoute_nxt;
	always_comb begin
		case (refSel_r)
			`REF_FIXED: refRoute_nxt = 3'h4;
			`REF_EXTERNAL: refRoute_nxt = 3'h2;
			`REF_SUPPLY: refRoute_nxt = 3'h1;
			default: refRoute_nxt = 3'h0;
		endcase
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			refRoute_r <= 3'h0;
			posLive_r <= 1'b0;
			negLive_r <= 1'b0;
			posInt_r <= 7'h00;
			negInt_r <= 7'h00;
			irq_r <= 1'b0;
		end else begin
			refRoute_r <= refRoute_nxt;
			posLive_r <= chanLive(posChan_r, 1'b0);
			negLive_r <= chanLive(negChan_r, 1'b1);
			posInt_r <= chanInternal(posChan_r);
			negInt_r <= chanInternal(negChan_r);
			irq_r <= irqEvent;
		end
	end

	// read data in the cycle after the strobe; unmapped reads zero
	byte_t rd_nxt;
	always_comb begin
		rd_nxt = 8'h00;
		if (hitPos)
			rd_nxt = {2'h0, posChan_r};
		else if (hitNeg)
			rd_nxt = {2'h0, negChan_r};
		else if (hitStat)
			rd_nxt = {ovf_r, upper_r, lower_r, upd_r, 1'b0,
				stageOf(stage_r)};
		else if (hitRef)
			rd_nxt = {6'h00, refSel_r};
		else if (hitDiv)
			rd_nxt = {2'h0, clkDiv_r};
		else if (hitCtl)
			rd_nxt = {3'h0, rcSrc_r, soi_r, double_sample_enable_r, continuous_operation_r, go_r};
		else if (hitMode)
			rd_nxt = {5'h00, tmd_r};
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn)
			rdata_r <= 8'h00;
		else if (regRd)
			rdata_r <= rd_nxt;
		else
			rdata_r <= 8'h00;
	end

	assign regRdata = rdata_r;
	assign thresholdIrq = irq_r;
	assign convClkTick = tick_r;
	assign refRoute = refRoute_r;
	assign posChannel = posChan_r;
	assign posConnected = posLive_r;
	assign posInternal = posInt_r;
	assign negChannel = negChan_r;
	assign negConnected = negLive_r;
	assign negInternal = negInt_r;
	assign stageCode = stageCode_r;
endmodule

// >>> adc_cfg.svh
// Purpose: offsets, field positions, reset values and codes
// Assumes: 16-bit register address, 8-bit register data
// Notes: control and mode registers sit after the status group
`ifndef ADC_CFG_SVH
`define ADC_CFG_SVH
`define ADDR_W 16
`define OFF_POS_CHAN 16'h1d1f
`define OFF_NEG_CHAN 16'h1d20
`define OFF_STATUS 16'h1d2a
`define OFF_REF_SEL 16'h1d2b
`define OFF_CLK_DIV 16'h1d2d
`define OFF_CONTROL 16'h1d30
`define OFF_TH_MODE 16'h1d31
`define RST_CHAN 6'h00
`define RST_REF 2'h0
`define RST_DIV 6'h00
`define RST_MODE 3'h0
`define ST_OVF 7
`define ST_UPPER 6
`define ST_LOWER 5
`define ST_UPD 4
`define CT_GO 0
`define CT_CONTINUOUS_OPERATION 1
`define CT_DOUBLE_SAMPLE_ENABLE 2
`define CT_SOI 3
`define CT_RCSRC 4
`define STAGE_IDLE 3'h0
`define STAGE_PRE1 3'h1
`define STAGE_ACQ1 3'h2
`define STAGE_CONV1 3'h3
`define STAGE_SUSP 3'h4
`define STAGE_PRE2 3'h5
`define STAGE_ACQ2 3'h6
`define STAGE_CONV2 3'h7
`define TMD_NEVER 3'h0
`define TMD_BELOW 3'h1
`define TMD_ATLEAST_LOW 3'h2
`define TMD_INSIDE 3'h3
`define TMD_OUTSIDE 3'h4
`define TMD_ATMOST_UP 3'h5
`define TMD_ABOVE 3'h6
`define TMD_ALWAYS 3'h7
`define REF_SUPPLY 2'h0
`define REF_EXTERNAL 2'h2
`define REF_FIXED 2'h3
`define CH_GUARD 6'h03
`define CH_INT_FIRST 6'h39
`define CH_GAP1_LO 6'h06
`define CH_GAP1_HI 6'h0b
`define CH_GAP2_LO 6'h18
`define CH_GAP2_HI 6'h38
`endif

// >>> adc_pkg.sv
// Purpose: shared types of the converter control block
// Assumes: constants come from adc_cfg.svh
// Notes: none
package adc_pkg;
	typedef enum logic [2:0] {
		stIdle, stPre1, stAcq1, stConv1, stSusp, stPre2, stAcq2, stConv2
	} stage_t;
	typedef logic [15:0] value_t;
	typedef logic [7:0] byte_t;
endpackage

// >>> adc_threshold_status_config_chk.sv
// Purpose: port-level checks of the converter control block
// Assumes: bound to the top module, one clock domain
// Notes: channel maps coded again here, not shared with the design
`timescale 1ns/10ps
`include "adc_cfg.svh"
module adc_threshold_status_config_chk (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [`ADDR_W-1:0] regAddr,
	input wire logic regRd,
	input wire adc_pkg::byte_t regRdata,
	input wire logic thresholdTest,
	input wire logic triggerIn,
	input wire logic prechargeDone,
	input wire logic thresholdIrq,
	input wire logic convClkTick,
	input wire logic [5:0] posChannel,
	input wire logic posConnected,
	input wire logic [6:0] posInternal,
	input wire logic [5:0] negChannel,
	input wire logic negConnected,
	input wire logic [6:0] negInternal,
	input wire logic [2:0] stageCode
);
	import adc_pkg::*;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	function automatic logic hit(logic [5:0] c, logic neg);
		return !(c inside {[`CH_GAP1_LO:`CH_GAP1_HI], [`CH_GAP2_LO:`CH_GAP2_HI]})
			&& !(neg && c == `CH_GUARD);
	endfunction
	// outputs trail the code by one register, so wait for it to settle
	sequence steady(logic [5:0] c);
		$past(resetn, 2) && $stable(c) && c == $past(c, 2);
	endsequence
	irq_cause_a: assert property (thresholdIrq |-> $past(thresholdTest))
		else $error("interrupt without a test one cycle before");
	tick_width_a: assert property (convClkTick |=> !convClkTick)
		else $error("converter tick longer than one cycle");
	pre_exit_a: assert property ($past(stageCode) == 3'h1 &&
		stageCode != 3'h1 |-> $past(prechargeDone) && stageCode == 3'h2)
		else $error("precharge stage left wrongly");
	susp_hold_a: assert property (stageCode == 3'h4 && !triggerIn |=>
		stageCode inside {3'h0, 3'h4})
		else $error("suspended stage left without trigger");
	susp_wake_a: assert property (stageCode == 3'h4 && triggerIn |=>
		stageCode == 3'h5)
		else $error("trigger did not start second precharge");
	stage_read_a: assert property ($past(regRd) &&
		$past(regAddr) == `OFF_STATUS |->
		regRdata[3:0] == {1'b0, $past(stageCode)})
		else $error("status read disagrees with stage code");
	pos_conn_a: assert property (steady(posChannel) |->
		posConnected == hit(posChannel, 1'b0))
		else $error("positive connection wrong for code");
	neg_conn_a: assert property (steady(negChannel) |->
		negConnected == hit(negChannel, 1'b1))
		else $error("negative connection wrong for code");
	pos_int_a: assert property (steady(posChannel) |->
		posInternal == (posChannel >= `CH_INT_FIRST ?
		7'h01 << (posChannel - `CH_INT_FIRST) : 7'h00))
		else $error("internal source select wrong");
	neg_int_a: assert property (steady(negChannel) |->
		negInternal == (negChannel >= `CH_INT_FIRST ?
		7'h01 << (negChannel - `CH_INT_FIRST) : 7'h00))
		else $error("negative internal source select wrong");
	cover property (stageCode == 3'h4 ##1 stageCode == 3'h5);
	cover property (thresholdIrq);
	cover property (steady(posChannel) and posInternal[6]);
endmodule
bind adc_threshold_status_config adc_threshold_status_config_chk
	adc_threshold_status_config_chk_inst (.core_clk, .resetn, .regAddr,
	.regRd, .regRdata, .thresholdTest, .triggerIn, .prechargeDone,
	.thresholdIrq, .convClkTick, .posChannel, .posConnected, .posInternal,
	.negChannel, .negConnected, .negInternal, .stageCode);

// >>> adc_threshold_status_config_test.sv
// Purpose: self-checking bench of the converter control block
// Assumes: read data one cycle after the strobe
// Notes: drivers queue expectations, monitors compare
`timescale 1ns/10ps
`include "adc_cfg.svh"
module adc_threshold_status_config_test;
	import adc_pkg::*;
	logic core_clk = 0, resetn = 0, regWr = 0, regRd = 0, rcClk = 0;
	logic [6:0] ev = 0;
	wire thresholdTest = ev[0], overflowEvent = ev[1], computeUpdate = ev[2];
	wire triggerIn = ev[3], prechargeDone = ev[4], acquireDone = ev[5];
	wire conversionDone = ev[6];
	logic [15:0] regAddr = 0;
	byte_t regWdata = 0, regRdata;
	value_t computedError = 0, upperThreshold = 0, lowerThreshold = 0;
	logic thresholdIrq, convClkTick, posConnected, negConnected;
	logic rdSeen = 0, tstSeen = 0;
	logic [2:0] refRoute, stageCode;
	logic [5:0] posChannel, negChannel;
	logic [6:0] posInternal, negInternal;
	logic [15:0] addrs[6] = '{`OFF_POS_CHAN, `OFF_NEG_CHAN, `OFF_STATUS,
		`OFF_REF_SEL, `OFF_CLK_DIV, 16'h1d2c};
	logic [2:0] routes[4] = '{3'b001, 3'b000, 3'b010, 3'b100};
	byte_t rdQ[$];
	logic irqQ[$];
	int gapQ[$];
	int bad_count = 0, samples_checked = 0, cycles = 0, gap = 0;
	always #50 core_clk = ~core_clk;
	// free-running; the 5 ns offset keeps its edges off core_clk edges
	initial begin
		#5;
		forever #170 rcClk = ~rcClk;
	end
	adc_threshold_status_config adc_threshold_status_config_inst (.core_clk,
		.resetn, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
		.computedError, .upperThreshold, .lowerThreshold, .thresholdTest,
		.overflowEvent, .computeUpdate, .triggerIn, .prechargeDone,
		.acquireDone, .conversionDone, .rcClk, .thresholdIrq, .convClkTick,
		.refRoute, .posChannel, .posConnected, .posInternal, .negChannel,
		.negConnected, .negInternal, .stageCode);
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tick(int n = 1);
		repeat (n) @(posedge core_clk);
	endtask
	// every driver ends with an idle cycle so strobes never double up
	task automatic wr(input logic [15:0] a, input byte_t d);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		tick();
		regWr <= 1'b0;
		tick();
	endtask
	task automatic rd(input logic [15:0] a, input byte_t e);
		rdQ.push_back(e);
		regAddr <= a;
		regRd <= 1'b1;
		tick();
		regRd <= 1'b0;
		tick();
	endtask
	task automatic pulse(int k);
		ev <= 7'h01 << k;
		tick();
		ev <= 7'h00;
		tick();
	endtask
	task automatic summarize();
		$display("%0d compared, %0d mismatches", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	always @(posedge core_clk) begin
		rdSeen <= regRd;
		tstSeen <= thresholdTest;
		cycles <= cycles + 1;
		gap <= convClkTick ? 1 : gap + 1;
		if (rdSeen && rdQ.size() > 0)
			chk(regRdata, rdQ.pop_front());
		if (tstSeen && irqQ.size() > 0)
			chk(thresholdIrq, irqQ.pop_front());
		if (convClkTick && gapQ.size() > 0)
			chk(16'(gap), gapQ.pop_front());
		if (cycles == 5000) begin
			bad_count++;
			summarize();
		end
	end
	initial begin
		logic [15:0] e, u, l;
		logic [7:0] w;
		logic ab, bl;
		byte_t st;
		int n;
		n = $urandom(62842);
		tick(2);
		resetn <= 1'b1;
		foreach (addrs[i]) rd(addrs[i], 8'h00);
		for (int c = 0; c < 64; c++) begin
			wr(`OFF_POS_CHAN, c[7:0]);
			wr(`OFF_NEG_CHAN, 8'(63 - c));
			tick();
			chk(posChannel, 16'(c));
			chk(negChannel, 16'(63 - c));
			rd(`OFF_POS_CHAN, c[7:0]);
			rd(`OFF_NEG_CHAN, 8'(63 - c));
		end
		for (int k = 0; k < 4; k++) begin
			wr(`OFF_REF_SEL, k[7:0]);
			tick(2);
			chk(refRoute, routes[k]);
		end
		$display("register map test done");
		for (int m = 0; m < 8; m++) begin
			wr(`OFF_TH_MODE, m[7:0]);
			for (int i = 0; i < 6; i++) begin
				e = 16'($urandom);
				u = (i == 1) ? e : 16'($urandom);
				l = (i == 2) ? e : 16'($urandom);
				computedError <= e;
				upperThreshold <= u;
				lowerThreshold <= l;
				ab = $signed(e) > $signed(u);
				bl = $signed(e) < $signed(l);
				w = {1'b1, ab, !ab, ab | bl,
					$signed(e) > $signed(l) && $signed(e) < $signed(u), !bl, bl, 1'b0};
				irqQ.push_back(w[m]);
				pulse(0);
				st = {1'b0, ab, bl, 5'h00};
				rd(`OFF_STATUS, st);
			end
		end
		$display("threshold test done");
		pulse(1);
		rd(`OFF_STATUS, st | 8'h90);
		wr(`OFF_STATUS, 8'h00);
		wr(`OFF_STATUS, 8'hff);
		rd(`OFF_STATUS, st);
		fork
			pulse(1);
			wr(`OFF_STATUS, 8'h00);
		join
		rd(`OFF_STATUS, st | 8'h90);
		wr(`OFF_STATUS, 8'h00);
		pulse(2);
		rd(`OFF_STATUS, st | 8'h10);
		$display("flag test done");
		wr(`OFF_CONTROL, 8'h05);
		pulse(3);
		pulse(4);
		rd(`OFF_STATUS, st | 8'h12);
		pulse(5);
		pulse(6);
		wr(`OFF_STATUS, 8'h00);
		rd(`OFF_STATUS, st | 8'h14);
		pulse(3);
		pulse(4);
		pulse(5);
		rd(`OFF_STATUS, st | 8'h17);
		pulse(6);
		rd(`OFF_CONTROL, 8'h04);
		wr(`OFF_STATUS, 8'h00);
		wr(`OFF_CONTROL, 8'h01);
		for (int k = 3; k < 7; k++) pulse(k);
		rd(`OFF_STATUS, st);
		wr(`OFF_CONTROL, 8'h0b);
		pulse(4);
		pulse(5);
		irqQ.push_back(1'b1);
		pulse(0);
		pulse(6);
		rd(`OFF_CONTROL, 8'h0a);
		rd(`OFF_STATUS, st);
		wr(`OFF_CONTROL, 8'h07);
		for (int k = 4; k < 7; k++) pulse(k);
		rd(`OFF_STATUS, st | 8'h05);
		wr(`OFF_CONTROL, 8'h06);
		for (int k = 4; k < 7; k++) pulse(k);
		rd(`OFF_STATUS, st);
		$display("stage test done");
		for (int i = 0; i < 3; i++) begin
			n = $urandom_range(7);
			wr(`OFF_CLK_DIV, n[7:0]);
			tick(40);
			gapQ.push_back(2 * (n + 1));
			tick(20);
		end
		wr(`OFF_CONTROL, 8'h10);
		tick(10);
		n = 0;
		repeat (170) @(negedge core_clk) n += convClkTick;
		tick();
		chk(n inside {[48:52]}, 1'b1);
		$display("divider test done");
		summarize();
	end
endmodule
